// *** rtl/timer2_control_flags.sv ***
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module timer2_control_flags #(
    parameter int DIV12_W = 4,
    parameter int RTC_DIV_W = 3
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic BIT_WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // neighbour controls
    input wire logic IRQ_ENABLE_I,
    input wire logic HIGH_BYTE_CLOCK_SELECT_I,
    input wire logic LOW_BYTE_CLOCK_SELECT_I,
    // asynchronous sources
    input wire logic COMPARATOR_I,
    input wire logic RTC_CLOCK_I,
    // interrupt request
    output logic IRQ_O
);
    import timer2_pkg::*;

    localparam logic [DIV12_W-1:0] DIV12_LAST = DIV12_W'(SYSTEM_CLOCK_DIV - 1);
    localparam logic [DIV12_W-1:0] DIV12_ONE = DIV12_W'(1);
    localparam logic [DIV12_W-1:0] DIV12_ZERO = '0;
    localparam logic [RTC_DIV_W-1:0] RTC_LAST = RTC_DIV_W'(RTC_DIV - 1);
    localparam logic [RTC_DIV_W-1:0] RTC_ONE = RTC_DIV_W'(1);
    localparam logic [RTC_DIV_W-1:0] RTC_ZERO = '0;

    // the clock chosen for one byte: system clock or the shared external one
    function automatic logic byte_tick(input logic sys_sel, input logic ext);
        byte_tick = sys_sel ? 1'b1 : ext;
    endfunction : byte_tick

    function automatic logic is_bit_of(input logic [7:0] addr, input logic [2:0] idx);
        is_bit_of = (addr == (ADDR_CTRL | {5'h00, idx}));
    endfunction : is_bit_of

    ctrl_t ctrl_reg, ctrl_next;
    word_t reload_reg, reload_next;
    word_t count_reg, count_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic [DIV12_W-1:0] div12_reg, div12_next;
    logic [RTC_DIV_W-1:0] rtc_div_reg, rtc_div_next;
    logic [2:0] cmp_sync_reg, cmp_sync_next;
    logic [2:0] rtc_sync_reg, rtc_sync_next;

    logic cmp_rise, rtc_rise, div12_tick, rtc8_tick, ext_tick, cap_trig;
    logic lo_tick, hi_tick, lo_ovf, hi_ovf, capture;
    logic bit_hit, ctrl_wr;

    // sources: stage 0 feeds stage 1 only; edges compare stages 1 and 2
    always_comb begin
        cmp_sync_next = {cmp_sync_reg[1:0], COMPARATOR_I};
        rtc_sync_next = {rtc_sync_reg[1:0], RTC_CLOCK_I};
        cmp_rise = cmp_sync_reg[1] & ~cmp_sync_reg[2];
        rtc_rise = rtc_sync_reg[1] & ~rtc_sync_reg[2];
        div12_tick = (div12_reg == DIV12_LAST);
        div12_next = div12_tick ? DIV12_ZERO : div12_reg + DIV12_ONE;
        rtc8_tick = rtc_rise && (rtc_div_reg == RTC_LAST);
        rtc_div_next = rtc_div_reg;
        if (rtc_rise) begin
            rtc_div_next = rtc8_tick ? RTC_ZERO : rtc_div_reg + RTC_ONE;
        end
        case (ctrl_reg.external_source_select)
            SRC_DIV12_RTC: begin
                ext_tick = div12_tick;
                cap_trig = rtc8_tick;
            end
            SRC_CMP_RTC: begin
                ext_tick = cmp_rise;
                cap_trig = rtc8_tick;
            end
            SRC_DIV12_CMP: begin
                ext_tick = div12_tick;
                cap_trig = cmp_rise;
            end
            default: begin
                ext_tick = rtc8_tick;
                cap_trig = cmp_rise;
            end
        endcase
    end

    // counter, reload and flags
    always_comb begin
        count_next = count_reg;
        reload_next = reload_reg;
        ctrl_next = ctrl_reg;
        lo_ovf = 1'b0;
        hi_ovf = 1'b0;
        lo_tick = 1'b0;
        hi_tick = 1'b0;
        capture = 1'b0;
        if (ctrl_reg.split_mode_select) begin
            lo_tick = byte_tick(LOW_BYTE_CLOCK_SELECT_I, ext_tick);
            hi_tick = ctrl_reg.run_control
                && byte_tick(HIGH_BYTE_CLOCK_SELECT_I, ext_tick);
            lo_ovf = lo_tick && (count_reg.lo == BYTE_MAX);
            hi_ovf = hi_tick && (count_reg.hi == BYTE_MAX);
            if (lo_tick) begin
                count_next.lo = lo_ovf ? reload_reg.lo : count_reg.lo + BYTE_ONE;
            end
            if (hi_tick) begin
                count_next.hi = hi_ovf ? reload_reg.hi : count_reg.hi + BYTE_ONE;
            end
        end else begin
            lo_tick = ctrl_reg.run_control && byte_tick(LOW_BYTE_CLOCK_SELECT_I, ext_tick);
            lo_ovf = lo_tick && (count_reg.lo == BYTE_MAX);
            hi_ovf = lo_ovf && (count_reg.hi == BYTE_MAX);
            if (lo_tick) begin
                count_next = word_t'(count_reg + 16'h0001);
            end
            // in capture mode the reload register holds captures, so the count wraps
            if (hi_ovf && !ctrl_reg.capture_enable) begin
                count_next = reload_reg;
            end
        end
        if (ctrl_reg.capture_enable && cap_trig) begin
            capture = 1'b1;
            reload_next = count_reg;
        end
        // software access: data writes beat hardware, flags do not
        if (WR_I) begin
            case (ADDR_I)
                ADDR_CTRL: ctrl_next = ctrl_t'(WDATA_I);
                ADDR_RELOAD_LO: reload_next.lo = WDATA_I;
                ADDR_RELOAD_HI: reload_next.hi = WDATA_I;
                ADDR_COUNT_LO: count_next.lo = WDATA_I;
                ADDR_COUNT_HI: count_next.hi = WDATA_I;
                default: ;
            endcase
        end
        if (BIT_WR_I && ((ADDR_I & BIT_ADDR_MASK) == ADDR_CTRL)) begin
            ctrl_next[ADDR_I[2:0]] = WDATA_I[0];
        end
        // hardware sets last so they win over a clear in the same cycle
        if (hi_ovf || capture) begin
            ctrl_next.high_byte_overflow_flag = 1'b1;
        end
        if (lo_ovf) begin
            ctrl_next.low_byte_overflow_flag = 1'b1;
        end
        // level request while a flag that may interrupt is pending
        irq_next = IRQ_ENABLE_I && (ctrl_next.high_byte_overflow_flag
            || (ctrl_next.low_byte_irq_enable && ctrl_next.low_byte_overflow_flag));
    end

    // read port: data stands only in the cycle after the strobe
    always_comb begin
        rdata_next = READ_IDLE;
        if (RD_I) begin
            case (ADDR_I)
                ADDR_CTRL: rdata_next = ctrl_reg;
                ADDR_RELOAD_LO: rdata_next = reload_reg.lo;
                ADDR_RELOAD_HI: rdata_next = reload_reg.hi;
                ADDR_COUNT_LO: rdata_next = count_reg.lo;
                ADDR_COUNT_HI: rdata_next = count_reg.hi;
                default: rdata_next = READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_reg <= ctrl_t'(CTRL_RESET);
            reload_reg <= {BYTE_RESET, BYTE_RESET};
            count_reg <= {BYTE_RESET, BYTE_RESET};
            rdata_reg <= READ_IDLE;
            irq_reg <= 1'b0;
            div12_reg <= DIV12_ZERO;
            rtc_div_reg <= RTC_ZERO;
            cmp_sync_reg <= 3'h0;
            rtc_sync_reg <= 3'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            reload_reg <= reload_next;
            count_reg <= count_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            div12_reg <= div12_next;
            rtc_div_reg <= rtc_div_next;
            cmp_sync_reg <= cmp_sync_next;
            rtc_sync_reg <= rtc_sync_next;
        end
    end

    assign RDATA_O = rdata_reg;
    assign IRQ_O = irq_reg;

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    assign ctrl_wr = WR_I && (ADDR_I == ADDR_CTRL);
    assign bit_hit = BIT_WR_I && ((ADDR_I & BIT_ADDR_MASK) == ADDR_CTRL);

    property p_bit_run_set;
        BIT_WR_I && is_bit_of(ADDR_I, BIT_RUN) && WDATA_I[0] |=> ctrl_reg.run_control;
    endproperty
    a_bit_run_set: assert property (p_bit_run_set) else $error("run bit not set");

    property p_split_high_wrap;
        ctrl_reg.split_mode_select && hi_tick && count_reg.hi == BYTE_MAX && !WR_I
            |=> ctrl_reg.high_byte_overflow_flag && count_reg.hi == $past(reload_reg.hi);
    endproperty
    a_split_high_wrap: assert property (p_split_high_wrap) else $error("high wrap");

    sequence s_full_wrap;
        !ctrl_reg.split_mode_select && lo_tick && count_reg == 16'hFFFF
            && !ctrl_reg.capture_enable && !WR_I && !BIT_WR_I;
    endsequence
    property p_full_wrap;
        s_full_wrap |=> ctrl_reg.high_byte_overflow_flag && count_reg == $past(reload_reg);
    endproperty
    a_full_wrap: assert property (p_full_wrap) else $error("16-bit reload");

    property p_low_wrap;
        lo_tick && count_reg.lo == BYTE_MAX |=> ctrl_reg.low_byte_overflow_flag;
    endproperty
    a_low_wrap: assert property (p_low_wrap) else $error("low flag");

    property p_flag_sticky;
        ctrl_reg.high_byte_overflow_flag && !ctrl_wr && !bit_hit
            |=> ctrl_reg.high_byte_overflow_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_set_beats_clear;
        ctrl_wr && !WDATA_I[BIT_LOW_OVF] && lo_ovf |=> ctrl_reg.low_byte_overflow_flag;
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear won");

    property p_irq_high;
        $past(IRQ_ENABLE_I) && ctrl_reg.high_byte_overflow_flag |-> IRQ_O;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("no high irq");

    property p_irq_low;
        $past(IRQ_ENABLE_I) && ctrl_reg.low_byte_irq_enable
            && ctrl_reg.low_byte_overflow_flag |-> IRQ_O;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("no low irq");

    property p_split_low_free;
        ctrl_reg.split_mode_select && !ctrl_reg.run_control && LOW_BYTE_CLOCK_SELECT_I
            |-> lo_tick && !hi_tick;
    endproperty
    a_split_low_free: assert property (p_split_low_free) else $error("split gating");

    property p_capture;
        ctrl_reg.capture_enable && cap_trig && !WR_I
            |=> reload_reg == $past(count_reg) && ctrl_reg.high_byte_overflow_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture");

    property p_src_cmp;
        ctrl_reg.external_source_select == SRC_CMP_RTC |-> ext_tick == cmp_rise;
    endproperty
    a_src_cmp: assert property (p_src_cmp) else $error("source 01");

    property p_src_rtc;
        ctrl_reg.external_source_select == SRC_RTC_CMP
            |-> ext_tick == rtc8_tick && cap_trig == cmp_rise;
    endproperty
    a_src_rtc: assert property (p_src_rtc) else $error("source 11");

    property p_sync_delay;
        cmp_rise |-> $past(COMPARATOR_I, 2) && !$past(COMPARATOR_I, 3);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync depth");

    property p_split_ext;
        ctrl_reg.split_mode_select && ctrl_reg.run_control && !HIGH_BYTE_CLOCK_SELECT_I
            |-> hi_tick == ext_tick;
    endproperty
    a_split_ext: assert property (p_split_ext) else $error("byte clock");

endmodule : timer2_control_flags

// *** rtl/timer2_pkg.sv ***
package timer2_pkg;

    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI = 8'hCD;

    // bit addresses of the control register span ADDR_CTRL + bit index
    localparam logic [7:0] BIT_ADDR_MASK = 8'hF8;
    localparam logic [2:0] BIT_HIGH_OVF = 3'h7;
    localparam logic [2:0] BIT_LOW_OVF = 3'h6;
    localparam logic [2:0] BIT_RUN = 3'h2;

    // reset values and limits
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // external source select codes
    localparam logic [1:0] SRC_DIV12_RTC = 2'h0;
    localparam logic [1:0] SRC_CMP_RTC = 2'h1;
    localparam logic [1:0] SRC_DIV12_CMP = 2'h2;
    localparam logic [1:0] SRC_RTC_CMP = 2'h3;

    // prescaler ratios
    localparam int SYSTEM_CLOCK_DIV = 12;
    localparam int RTC_DIV = 8;

    typedef struct packed {
        logic high_byte_overflow_flag;
        logic low_byte_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_enable;
        logic split_mode_select;
        logic run_control;
        logic [1:0] external_source_select;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } word_t;

endpackage : timer2_pkg

// *** verification/timer2_control_flags_bench.sv ***
`timescale 1ns/1ns
module timer2_control_flags_bench;
    import timer2_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic bit_wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic ie = 1'b0;
    logic hb_sel = 1'b0;
    logic lb_sel = 1'b0;
    logic cmp = 1'b0;
    logic rtc = 1'b0;
    logic irq;
    logic [31:0] seed = 32'h65956A84;
    logic [7:0] got;
    logic [7:0] rl;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0;
    int exp_lo;
    int exp_hi;

    timer2_control_flags timer2_control_flags_i (
        .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .BIT_WR_I(bit_wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_ENABLE_I(ie),
        .HIGH_BYTE_CLOCK_SELECT_I(hb_sel), .LOW_BYTE_CLOCK_SELECT_I(lb_sel),
        .COMPARATOR_I(cmp), .RTC_CLOCK_I(rtc), .IRQ_O(irq)
    );

    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // maximal-length taps, so the run repeats from the fixed seed
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic do_reset();
        rstn <= 1'b0;
        step(20);
        rstn <= 1'b1;
        step(1);
    endtask : do_reset

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic bwr(input logic [2:0] b, input logic v);
        @(posedge clk);
        addr <= ADDR_CTRL + {5'h00, b};
        wdata <= {7'h00, v};
        bit_wr <= 1'b1;
        @(posedge clk);
        bit_wr <= 1'b0;
    endtask : bwr

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // taken at the next edge, before the register drops back to idle
        @(posedge clk);
        d = rdata;
    endtask : rd_reg

    task automatic check(input logic [7:0] g, input logic [7:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
            err_total++;
        end
    endtask : check

    task automatic check_rng(input logic [7:0] g, input int lo, input int hi, input string m);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            $display("unexpected at %0t: %s got %h range %0d..%0d", $time, m, g, lo, hi);
            err_total++;
        end
    endtask : check_rng

    task automatic conclude();
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        #(40 * 6000);
        err_total++;
        conclude();
    end

    initial begin
        do_reset();
        for (int i = 0; i < 6; i++) begin
            rd_reg(8'hC8 + i[7:0], got);
            check(got, 8'h00, "reset value");
        end
        wr_reg(ADDR_CTRL, 8'h38);
        rd_reg(ADDR_CTRL, got);
        check(got, 8'h38, "control readback");
        bwr(3'h4, 1'b0);
        bwr(3'h0, 1'b1);
        rd_reg(ADDR_CTRL, got);
        check(got, 8'h29, "bit access");
        wr_reg(ADDR_CTRL, 8'h00);
        rl = rnd();
        wr_reg(ADDR_RELOAD_LO, rl);
        wr_reg(ADDR_RELOAD_HI, 8'h12);
        wr_reg(ADDR_COUNT_HI, 8'hFF);
        wr_reg(ADDR_COUNT_LO, 8'hF8);
        lb_sel <= 1'b1;
        wr_reg(ADDR_CTRL, 8'h04);
        step(12);
        bwr(BIT_RUN, 1'b0);
        step(rnd() % 8);
        rd_reg(ADDR_CTRL, got);
        check(got & 8'h80, 8'h80, "word overflow flag");
        rd_reg(ADDR_COUNT_HI, got);
        check(got, 8'h12, "reload high");
        rd_reg(ADDR_RELOAD_LO, got);
        check(got, rl, "reload kept");
        check({7'h00, irq}, 8'h00, "irq masked");
        ie <= 1'b1;
        step(2);
        check({7'h00, irq}, 8'h01, "irq on high flag");
        bwr(BIT_HIGH_OVF, 1'b0);
        bwr(BIT_LOW_OVF, 1'b0);
        step(2);
        check({7'h00, irq}, 8'h00, "irq after clear");
        // split: low byte free-runs, high byte held by run bit
        hb_sel <= 1'b1;
        wr_reg(ADDR_COUNT_HI, 8'hFF);
        wr_reg(ADDR_COUNT_LO, 8'hF0);
        wr_reg(ADDR_CTRL, 8'h28);
        step(24);
        rd_reg(ADDR_CTRL, got);
        check(got & 8'hC0, 8'h40, "low flag only");
        check({7'h00, irq}, 8'h01, "low byte irq");
        rd_reg(ADDR_COUNT_HI, got);
        check(got, 8'hFF, "high byte gated");
        bwr(BIT_RUN, 1'b1);
        step(3);
        rd_reg(ADDR_CTRL, got);
        check(got & 8'h80, 8'h80, "byte overflow flag");
        wr_reg(ADDR_CTRL, 8'h00);
        ie <= 1'b0;
        lb_sel <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            do_reset();
            wr_reg(ADDR_CTRL, 8'h04 | c[7:0]);
            t0 = cyc;
            for (int i = 0; i < 16; i++) begin
                rtc <= 1'b1;
                step(1 + rnd() % 4);
                rtc <= 1'b0;
                cmp <= (i % 4 == 0);
                step(1 + rnd() % 4);
            end
            step(6);
            bwr(BIT_RUN, 1'b0);
            exp_lo = (c == 1) ? 4 : (c == 3) ? 2 : (cyc - t0) / 12 - 1;
            exp_hi = (c == 1) ? 4 : (c == 3) ? 2 : (cyc - t0) / 12 + 1;
            rd_reg(ADDR_COUNT_LO, got);
            check_rng(got, exp_lo, exp_hi, "external tick count");
        end
        do_reset();
        lb_sel <= 1'b1;
        wr_reg(ADDR_CTRL, 8'h16);
        step(10);
        cmp <= 1'b1;
        step(8);
        cmp <= 1'b0;
        rd_reg(ADDR_CTRL, got);
        check(got & 8'h80, 8'h80, "capture flag");
        rd_reg(ADDR_RELOAD_LO, got);
        check_rng(got, 8, 40, "captured count");
        rd_reg(ADDR_RELOAD_HI, got);
        check(got, 8'h00, "captured high");
        // byte write clearing the low flag lands on the low-byte wrap edge
        wr_reg(ADDR_CTRL, 8'h08);
        wr_reg(ADDR_COUNT_LO, 8'hFE);
        wr_reg(ADDR_CTRL, 8'h08);
        rd_reg(ADDR_CTRL, got);
        check(got, 8'h48, "set beats clear");
        conclude();
    end
endmodule : timer2_control_flags_bench
